/* File: itfm_pkg.sv */
// package for the input terminal function mux: register map, field layout,
// reset values, selection codes and the digit helper.
// assumes a 16-bit register port with an 8-bit byte address.
package itfm_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ITFM_DW = 16;
   localparam int ITFM_AW = 8;
   localparam int ITFM_NUM_TERM = 4;

   // ----------------------------------------------------------------
   // register offsets (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_MODE_CHANGE = 8'h00;
   localparam logic [7:0] REG_MASTER_ASSIGN = 8'h04;
   localparam logic [7:0] REG_TERM_A = 8'h08;
   localparam logic [7:0] REG_TERM_B = 8'h0C;
   localparam logic [7:0] REG_TERM_C = 8'h10;
   localparam logic [7:0] REG_AUTO_ON = 8'h14;
   localparam logic [7:0] REG_STROKE_SEL = 8'h18;
   localparam logic [7:0] REG_CTRL_MODE = 8'h1C;
   localparam logic [7:0] REG_FUNC_STATUS = 8'h20;
   localparam logic [7:0] REG_LINE_STATUS = 8'h24;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_MODE_CHANGE = 16'h0002;
   localparam logic [15:0] RST_MASTER_ASSIGN = 16'h0111;
   localparam logic [15:0] RST_TERM_A = 16'h0882;
   localparam logic [15:0] RST_TERM_B = 16'h0995;
   localparam logic [15:0] RST_TERM_C = 16'h0000;
   localparam logic [15:0] RST_AUTO_ON = 16'h0000;
   localparam logic [15:0] RST_STROKE_SEL = 16'h0403;
   localparam logic [15:0] RST_CTRL_MODE = 16'h0000;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int POS_DIGIT_LSB = 4;
   localparam int SPD_DIGIT_LSB = 8;
   localparam int MODE_IN_SEL_LSB = 0;
   localparam int CLR_LEVEL_BIT = 4;
   localparam int AUTO_DRIVE_BIT = 0;
   localparam int AUTO_FWD_BIT = 4;
   localparam int AUTO_REV_BIT = 8;
   localparam int FWD_SEL_LSB = 0;
   localparam int REV_SEL_LSB = 8;
   localparam int CTRL_SPEED_BIT = 0;

   // ----------------------------------------------------------------
   // selection codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_IN_NONE = 4'h0;
   localparam logic [3:0] MODE_IN_PIN3 = 4'h1;
   localparam logic [3:0] MODE_IN_PIN4 = 4'h2;
   localparam logic [3:0] MODE_IN_PIN6 = 4'h3;
   // stroke-end selection codes are terminal pin numbers
   localparam logic [3:0] SE_PIN3 = 4'h3;
   localparam logic [3:0] SE_PIN4 = 4'h4;
   localparam logic [3:0] SE_PIN5 = 4'h5;
   localparam logic [3:0] SE_PIN6 = 4'h6;
   // function codes: 0 leaves the terminal unassigned
   localparam logic [3:0] FN_NONE = 4'h0;
   localparam logic [3:0] FN_DRIVE_ENABLE = 4'h1;
   localparam logic [3:0] FN_DROOP_CLEAR = 4'h4;

   typedef enum logic {
      MODE_POSITION,
      MODE_SPEED
   } itfm_mode_type;

   // pick the function digit that belongs to the active control mode
   function automatic logic [3:0] itfm_digit(input logic [15:0] word, input logic speed);
      logic [3:0] d;
      d = speed ? word[SPD_DIGIT_LSB +: 4] : word[POS_DIGIT_LSB +: 4];
      return d;
   endfunction : itfm_digit

endpackage : itfm_pkg

/* File: itfm_term_if.sv */
// interface between the mux core and one terminal decoder.
// assumes itfm_pkg is compiled first.
`timescale 1ns/1ns
interface itfm_term_if;
   logic [15:0] sel_word;
   logic speed_mode;
   logic pin_level;
   logic enable;
   logic [15:0] func_vec;
   modport owner (output sel_word, output speed_mode, output pin_level, output enable,
                  input func_vec);
   modport decoder (input sel_word, input speed_mode, input pin_level, input enable,
                    output func_vec);
endinterface : itfm_term_if

/* File: itfm_term_decoder.sv */
// one terminal decoder: turns a selection word and a pin level into a
// one-hot vector of asserted input functions.
// assumes the owner registers the result; this module is purely combinational.
`timescale 1ns/1ns
module itfm_term_decoder (
   itfm_term_if.decoder term
);
   import itfm_pkg::*;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // same digit coding for every terminal word and the master word
   always_comb begin
      logic [3:0] code;
      code = itfm_digit(term.sel_word, term.speed_mode);
      term.func_vec = '0;
      if (term.enable && (code != FN_NONE)) begin
         term.func_vec[code] = term.pin_level;
      end
   end

endmodule : itfm_term_decoder

/* File: itfm_input_mux.sv */
// input terminal function mux: configuration words, terminal routing,
// auto-on forcing and droop clear shaping for the signal_io_connector inputs.
// assumes terminal levels are synchronous to i_core_clk, high means on.
//
// How it works
// - mode change word picks control mode input terminal and clear style; resets 0002.
// - pin 3 carries the function chosen by its word; resets 0882.
// - pin 5 carries the function chosen by its word; resets 0995.
// - pin 6 carries the function chosen by its word; resets 0000.
// - all terminal words use the same function codes as the master word.
// - pin 3 word ignored while the mode change input sits on pin 3.
// - pin 3 word ignored while both travel limits sit on pin 3.
// - pin 6 word ignored while the mode change input sits on pin 6.
// - pin 6 word ignored while the reverse travel limit sits on pin 6.
// - auto-on bits force drive enable or travel limits on without wiring.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module itfm_input_mux (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [itfm_pkg::ITFM_AW-1:0] i_addr,
   input wire logic [itfm_pkg::ITFM_DW-1:0] i_wr_data,
   input wire logic i_wr_strobe,
   input wire logic i_rd_strobe,
   input wire logic i_pin3,
   input wire logic i_pin4,
   input wire logic i_pin5,
   input wire logic i_pin6,
   output logic [itfm_pkg::ITFM_DW-1:0] o_rd_data_q,
   output logic [15:0] o_func_q,
   output logic o_speed_mode_q,
   output logic o_drive_enable_q,
   output logic o_fwd_limit_q,
   output logic o_rev_limit_q,
   output logic o_droop_clear_q
);
   import itfm_pkg::*;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [15:0] mode_change_q;
   logic [15:0] master_assign_q;
   logic [15:0] term_a_q;
   logic [15:0] term_b_q;
   logic [15:0] term_c_q;
   logic [15:0] auto_on_q;
   logic [15:0] stroke_sel_q;
   logic [15:0] ctrl_mode_q;
   logic clear_prev_q;

   // words apply at once; no power cycle is modelled
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         mode_change_q <= RST_MODE_CHANGE;
         master_assign_q <= RST_MASTER_ASSIGN;
         term_a_q <= RST_TERM_A;
         term_b_q <= RST_TERM_B;
         term_c_q <= RST_TERM_C;
         auto_on_q <= RST_AUTO_ON;
         stroke_sel_q <= RST_STROKE_SEL;
         ctrl_mode_q <= RST_CTRL_MODE;
      end else if (i_wr_strobe) begin
         if (i_addr == REG_MODE_CHANGE) begin
            mode_change_q <= i_wr_data;
         end else if (i_addr == REG_MASTER_ASSIGN) begin
            master_assign_q <= i_wr_data;
         end else if (i_addr == REG_TERM_A) begin
            term_a_q <= i_wr_data;
         end else if (i_addr == REG_TERM_B) begin
            term_b_q <= i_wr_data;
         end else if (i_addr == REG_TERM_C) begin
            term_c_q <= i_wr_data;
         end else if (i_addr == REG_AUTO_ON) begin
            auto_on_q <= i_wr_data;
         end else if (i_addr == REG_STROKE_SEL) begin
            stroke_sel_q <= i_wr_data;
         end else if (i_addr == REG_CTRL_MODE) begin
            ctrl_mode_q <= i_wr_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // terminal selection
   // ----------------------------------------------------------------
   // level of the terminal that a stroke-end or mode change code names
   function automatic logic pin_by_pinnum(input logic [3:0] num, input logic [3:0] pins);
      logic lvl;
      lvl = 1'b0;
      if (num == SE_PIN3) begin
         lvl = pins[0];
      end else if (num == SE_PIN4) begin
         lvl = pins[1];
      end else if (num == SE_PIN5) begin
         lvl = pins[2];
      end else if (num == SE_PIN6) begin
         lvl = pins[3];
      end
      return lvl;
   endfunction : pin_by_pinnum

   logic [3:0] pins;
   logic [3:0] mode_in_sel;
   logic [3:0] fwd_sel;
   logic [3:0] rev_sel;
   logic [3:0] mode_in_pinnum;
   logic speed_mode;
   logic [ITFM_NUM_TERM-1:0] term_en;
   logic [15:0] term_word [ITFM_NUM_TERM];
   logic [ITFM_NUM_TERM-1:0] term_pin;
   logic [15:0] dec_vec [ITFM_NUM_TERM];
   logic [15:0] func_all;
   logic fwd_ext;
   logic rev_ext;
   logic clear_level;

   assign pins = {i_pin6, i_pin5, i_pin4, i_pin3};
   assign mode_in_sel = mode_change_q[MODE_IN_SEL_LSB +: 4];
   assign fwd_sel = stroke_sel_q[FWD_SEL_LSB +: 4];
   assign rev_sel = stroke_sel_q[REV_SEL_LSB +: 4];

   // map the mode change selection code onto a terminal pin number
   always_comb begin
      mode_in_pinnum = 4'h0;
      if (mode_in_sel == MODE_IN_PIN3) begin
         mode_in_pinnum = SE_PIN3;
      end else if (mode_in_sel == MODE_IN_PIN4) begin
         mode_in_pinnum = SE_PIN4;
      end else if (mode_in_sel == MODE_IN_PIN6) begin
         mode_in_pinnum = SE_PIN6;
      end
   end

   // unassigned mode change input falls back to the software mode bit
   assign speed_mode = (mode_in_pinnum != 4'h0) ? pin_by_pinnum(mode_in_pinnum, pins)
                                                : ctrl_mode_q[CTRL_SPEED_BIT];

   // pins 3 and 6 drop their own words only under the claims below; pin 5 never does
   assign term_en[0] = (mode_in_sel != MODE_IN_PIN3)
                       && !((fwd_sel == SE_PIN3) && (rev_sel == SE_PIN3));
   assign term_en[1] = 1'b1;
   assign term_en[2] = (mode_in_sel != MODE_IN_PIN6)
                       && (rev_sel != SE_PIN6);
   // the master terminal gives way to any other claim on pin 4
   assign term_en[3] = (mode_in_sel != MODE_IN_PIN4)
                       && (fwd_sel != SE_PIN4) && (rev_sel != SE_PIN4);

   assign term_word[0] = term_a_q;
   assign term_word[1] = term_b_q;
   assign term_word[2] = term_c_q;
   assign term_word[3] = master_assign_q;
   assign term_pin = {i_pin4, i_pin6, i_pin5, i_pin3};

   // ----------------------------------------------------------------
   // per-terminal decoders
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ITFM_NUM_TERM; g++) begin : g_term
         itfm_term_if term ();
         assign term.sel_word = term_word[g];
         assign term.speed_mode = speed_mode;
         assign term.pin_level = term_pin[g];
         assign term.enable = term_en[g];
         assign dec_vec[g] = term.func_vec;
         itfm_term_decoder u_dec (
            .term(term.decoder)
         );
      end
   endgenerate

   // a function wired to several terminals is on when any of them is on
   always_comb begin
      func_all = '0;
      for (int k = 0; k < ITFM_NUM_TERM; k++) begin
         func_all = func_all | dec_vec[k];
      end
   end

   // limits read their pin directly; a terminal word cannot feed them
   assign fwd_ext = pin_by_pinnum(fwd_sel, pins);
   assign rev_ext = pin_by_pinnum(rev_sel, pins);
   assign clear_level = func_all[FN_DROOP_CLEAR];

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // one register stage keeps every output glitch free
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_func_q <= '0;
         o_speed_mode_q <= 1'b0;
         o_drive_enable_q <= 1'b0;
         o_fwd_limit_q <= 1'b0;
         o_rev_limit_q <= 1'b0;
      end else begin
         o_func_q <= func_all;
         o_speed_mode_q <= speed_mode;
         o_drive_enable_q <= auto_on_q[AUTO_DRIVE_BIT] | func_all[FN_DRIVE_ENABLE];
         o_fwd_limit_q <= auto_on_q[AUTO_FWD_BIT] | fwd_ext;
         o_rev_limit_q <= auto_on_q[AUTO_REV_BIT] | rev_ext;
      end
   end

   // droop clear: level style follows the input, edge style pulses once
   // per rising edge so a stuck input cannot hold the droop cleared
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         clear_prev_q <= 1'b0;
         o_droop_clear_q <= 1'b0;
      end else begin
         clear_prev_q <= clear_level;
         if (mode_change_q[CLR_LEVEL_BIT]) begin
            o_droop_clear_q <= clear_level;
         end else begin
            o_droop_clear_q <= clear_level & ~clear_prev_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // data stand only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rd_data_q <= '0;
      end else if (!i_rd_strobe) begin
         o_rd_data_q <= '0;
      end else if (i_addr == REG_MODE_CHANGE) begin
         o_rd_data_q <= mode_change_q;
      end else if (i_addr == REG_MASTER_ASSIGN) begin
         o_rd_data_q <= master_assign_q;
      end else if (i_addr == REG_TERM_A) begin
         o_rd_data_q <= term_a_q;
      end else if (i_addr == REG_TERM_B) begin
         o_rd_data_q <= term_b_q;
      end else if (i_addr == REG_TERM_C) begin
         o_rd_data_q <= term_c_q;
      end else if (i_addr == REG_AUTO_ON) begin
         o_rd_data_q <= auto_on_q;
      end else if (i_addr == REG_STROKE_SEL) begin
         o_rd_data_q <= stroke_sel_q;
      end else if (i_addr == REG_CTRL_MODE) begin
         o_rd_data_q <= ctrl_mode_q;
      end else if (i_addr == REG_FUNC_STATUS) begin
         o_rd_data_q <= o_func_q;
      end else if (i_addr == REG_LINE_STATUS) begin
         o_rd_data_q <= {8'h00, term_en, o_droop_clear_q, o_rev_limit_q,
                         o_fwd_limit_q, o_drive_enable_q};
      end else begin
         o_rd_data_q <= '0;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_mode_word_reset: assert property (@(posedge i_core_clk)
      $fell(i_reset) |-> mode_change_q == RST_MODE_CHANGE)
      else $error("mode change word not at reset value");
   a_term_a_reset: assert property (@(posedge i_core_clk)
      $fell(i_reset) |-> term_a_q == RST_TERM_A)
      else $error("terminal a word not at reset value");
   a_term_b_reset: assert property (@(posedge i_core_clk)
      $fell(i_reset) |-> term_b_q == RST_TERM_B)
      else $error("terminal b word not at reset value");
   a_term_c_reset: assert property (@(posedge i_core_clk)
      $fell(i_reset) |-> term_c_q == RST_TERM_C)
      else $error("terminal c word not at reset value");
   a_term_b_route: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_pin5 && itfm_digit(term_b_q, speed_mode) != FN_NONE)
      |=> o_func_q[$past(itfm_digit(term_b_q, speed_mode))])
      else $error("pin 5 function not asserted");
   // blocked terminals: the decoder output itself must be empty
   a_pin3_mode_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (mode_in_sel == MODE_IN_PIN3) |-> dec_vec[0] == 16'h0000)
      else $error("pin 3 word used while mode change input on pin 3");
   a_pin3_se_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (fwd_sel == SE_PIN3 && rev_sel == SE_PIN3 && i_pin3) |-> dec_vec[0] == 16'h0000)
      else $error("pin 3 word used while both limits on pin 3");
   a_pin6_mode_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (mode_in_sel == MODE_IN_PIN6 && i_pin6) |-> dec_vec[2] == 16'h0000)
      else $error("pin 6 word used while mode change input on pin 6");
   a_pin6_se_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (rev_sel == SE_PIN6 && i_pin6) |-> dec_vec[2] == 16'h0000)
      else $error("pin 6 word used while reverse limit on pin 6");
   a_master_block: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (mode_in_sel == MODE_IN_PIN4) |-> dec_vec[3] == 16'h0000)
      else $error("master word used while mode change input on pin 4");

   // auto-on forcing and the plain limit path
   a_auto_drive_on: assert property (@(posedge i_core_clk) disable iff (i_reset)
      auto_on_q[AUTO_DRIVE_BIT] |=> o_drive_enable_q)
      else $error("drive enable not forced on");
   a_fwd_follow: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (!auto_on_q[AUTO_FWD_BIT] && fwd_sel == SE_PIN3) |=> o_fwd_limit_q == $past(i_pin3))
      else $error("forward limit does not follow its pin");
   a_rev_follow: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (!auto_on_q[AUTO_REV_BIT] && rev_sel == SE_PIN6) |=> o_rev_limit_q == $past(i_pin6))
      else $error("reverse limit does not follow its pin");

   // clear shaping: level style copies, edge style never stays high
   a_level_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
      mode_change_q[CLR_LEVEL_BIT] |=> o_droop_clear_q == $past(clear_level))
      else $error("level clear does not follow its input");
   a_edge_clear_once: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (o_droop_clear_q && !mode_change_q[CLR_LEVEL_BIT]) |=> !o_droop_clear_q)
      else $error("edge clear held longer than one cycle");

   // software mode bit reaches the output two cycles after its write
   a_soft_mode_sel: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_wr_strobe && i_addr == REG_CTRL_MODE && mode_in_sel == MODE_IN_NONE
       && !(i_wr_strobe && i_addr == REG_MODE_CHANGE))
      |=> ##1 (o_speed_mode_q == $past(i_wr_data[CTRL_SPEED_BIT], 2)
               || mode_in_sel != MODE_IN_NONE))
      else $error("software control mode not applied");

   // read port: data stand one cycle, zero otherwise
   a_read_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
      !i_rd_strobe |=> o_rd_data_q == 16'h0000)
      else $error("read data not zero without a strobe");
   a_read_term_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_rd_strobe && i_addr == REG_TERM_A) |=> o_rd_data_q == $past(term_a_q))
      else $error("terminal a readback wrong");

   c_speed_mode: cover property (@(posedge i_core_clk) disable iff (i_reset)
      $rose(o_speed_mode_q));
   c_clear_pulse: cover property (@(posedge i_core_clk) disable iff (i_reset)
      $rose(o_droop_clear_q) ##1 !o_droop_clear_q);
   c_pin3_blocked: cover property (@(posedge i_core_clk) disable iff (i_reset)
      !term_en[0] && i_pin3);
   c_auto_limit: cover property (@(posedge i_core_clk) disable iff (i_reset)
      auto_on_q[AUTO_FWD_BIT] && !fwd_ext && o_fwd_limit_q);

endmodule : itfm_input_mux

/* File: itfm_ctrl_model.sv */
// external controller model: drives the four input terminals of the mux.
// assumes the bench hands it target levels and it launches them on the clock.
`timescale 1ns/1ns
module itfm_ctrl_model (
   input wire logic i_core_clk,
   input wire logic i_slow,
   input wire logic [3:0] i_levels,
   output logic o_pin3,
   output logic o_pin4,
   output logic o_pin5,
   output logic o_pin6
);
   logic [3:0] stage_q = 4'h0;
   logic [3:0] pins_q = 4'h0;

   // ----------------------------------------------------------------
   // terminal launch
   // ----------------------------------------------------------------
   // slow mode adds a cycle of wiring delay, like a relay contact settling
   always @(posedge i_core_clk) begin
      stage_q <= i_levels;
      pins_q <= i_slow ? stage_q : i_levels;
   end

   // pins are plain driven levels, so they never float
   assign {o_pin6, o_pin5, o_pin4, o_pin3} = pins_q;
endmodule : itfm_ctrl_model

/* File: test_input_terminal_function_mux.sv */
// self-checking bench for the input terminal function mux.
// assumes itfm_pkg, the interface, the decoder and the controller model.
`timescale 1ns/1ns
module test_input_terminal_function_mux;
   import itfm_pkg::*;
   typedef struct {
      logic [7:0] addr;
      logic [15:0] word;
      logic [3:0] pins;
      logic [15:0] exp_func;
      logic exp_speed;
      logic exp_drive;
   } itfm_row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slow = 1'b0;
   logic [3:0] lv = 4'h0;
   logic pin3, pin4, pin5, pin6;
   logic [15:0] rdata, func, got;
   logic speed, drive, fwd, rev, clr;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   int highs;
   itfm_row_type rows [8];
   logic [7:0] rst_addr [6];
   logic [15:0] rst_val [6];

   // ----------------------------------------------------------------
   // clock, partner and design
   // ----------------------------------------------------------------
   always #25 clk = ~clk;

   itfm_ctrl_model i_ctrl (.i_core_clk(clk), .i_slow(slow), .i_levels(lv), .o_pin3(pin3),
      .o_pin4(pin4), .o_pin5(pin5), .o_pin6(pin6));

   itfm_input_mux i_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr), .i_wr_data(wdata),
      .i_wr_strobe(wr), .i_rd_strobe(rd), .i_pin3(pin3), .i_pin4(pin4), .i_pin5(pin5),
      .i_pin6(pin6), .o_rd_data_q(rdata), .o_func_q(func), .o_speed_mode_q(speed),
      .o_drive_enable_q(drive), .o_fwd_limit_q(fwd), .o_rev_limit_q(rev),
      .o_droop_clear_q(clr));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_word

   task automatic chk_bit(input logic g, input logic e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
      end
   endtask : chk_bit

   // one-cycle write strobe, launched just after an edge
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe, so sample mid-cycle there
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg

   // margin covers the slow partner stage plus the registered outputs
   task automatic apply(input logic [3:0] p);
      @(posedge clk);
      lv <= p;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : apply

   // ----------------------------------------------------------------
   // timeout
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rows = '{'{REG_TERM_A, 16'h0A30, 4'h1, 16'h0008, 1'b0, 1'b0},
               '{REG_TERM_A, 16'h0A30, 4'h3, 16'h0400, 1'b1, 1'b0},
               '{REG_TERM_B, 16'h0C70, 4'h4, 16'h0080, 1'b0, 1'b0},
               '{REG_TERM_B, 16'h0C70, 4'h6, 16'h1000, 1'b1, 1'b0},
               '{REG_TERM_C, 16'h0E60, 4'h8, 16'h0040, 1'b0, 1'b0},
               '{REG_TERM_C, 16'h0E60, 4'hA, 16'h4000, 1'b1, 1'b0},
               '{REG_TERM_C, 16'h0E60, 4'hD, 16'h00C8, 1'b0, 1'b0},
               '{REG_TERM_B, 16'h0510, 4'h4, 16'h0002, 1'b0, 1'b1}};
      rst_addr = '{REG_MODE_CHANGE, REG_MASTER_ASSIGN, REG_TERM_A, REG_TERM_B, REG_TERM_C, 8'h30};
      rst_val = '{16'h0002, 16'h0111, 16'h0882, 16'h0995, 16'h0000, 16'h0000};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // a write to an unmapped place must leave the mode change, master and three terminal words at their reset values
      wr_reg(8'h30, 16'hFFFF);
      for (int i = 0; i < 6; i++) begin
         rd_reg(rst_addr[i], got);
         chk_word(got, rst_val[i], "reset value");
      end
      $display("test reset values done");
      // default words put the mode input on pin 4, so pin 4 picks the digit
      foreach (rows[i]) begin
         slow <= i[0];
         wr_reg(rows[i].addr, rows[i].word);
         rd_reg(rows[i].addr, got);
         chk_word(got, rows[i].word, "word readback");
         apply(rows[i].pins);
         chk_word(func, rows[i].exp_func, "function vector");
         chk_bit(speed, rows[i].exp_speed, "speed mode");
         chk_bit(drive, rows[i].exp_drive, "drive enable");
         apply(4'h0);
      end
      $display("test routing rows done");
      wr_reg(REG_TERM_A, 16'h0A30);
      wr_reg(REG_MODE_CHANGE, 16'h0001);
      apply(4'h1);
      chk_word(func, 16'h0000, "pin3 word used under mode input");
      chk_bit(speed, 1'b1, "mode input on pin3");
      wr_reg(REG_MODE_CHANGE, 16'h0003);
      apply(4'h8);
      chk_word(func, 16'h0000, "pin6 word used under mode input");
      chk_bit(speed, 1'b1, "mode input on pin6");
      $display("test mode input blocking done");
      wr_reg(REG_MODE_CHANGE, 16'h0000);
      wr_reg(REG_STROKE_SEL, 16'h0303);
      apply(4'h1);
      chk_word(func, 16'h0000, "pin3 word used under both limits");
      chk_bit(rev, 1'b1, "reverse limit on pin3");
      wr_reg(REG_STROKE_SEL, 16'h0603);
      apply(4'h8);
      chk_word(func, 16'h0000, "pin6 word used under reverse limit");
      chk_bit(rev, 1'b1, "reverse limit on pin6");
      $display("test limit blocking done");
      apply(4'h0);
      wr_reg(REG_AUTO_ON, 16'h0111);
      apply(4'h0);
      chk_bit(drive, 1'b1, "auto drive enable");
      chk_bit(fwd, 1'b1, "auto forward limit");
      chk_bit(rev, 1'b1, "auto reverse limit");
      wr_reg(REG_AUTO_ON, 16'h0000);
      apply(4'h0);
      chk_bit(drive, 1'b0, "drive enable follows pin");
      $display("test auto on done");
      // edge style clear gives a single pulse while the pin stays high
      wr_reg(REG_TERM_A, 16'h0040);
      @(posedge clk);
      lv <= 4'h1;
      highs = 0;
      repeat (8) begin
         @(negedge clk);
         highs += (clr === 1'b1) ? 1 : 0;
      end
      chk_word(16'(highs), 16'h0001, "edge clear pulse count");
      wr_reg(REG_MODE_CHANGE, 16'h0010);
      apply(4'h1);
      chk_bit(clr, 1'b1, "level clear held");
      $display("test clear style done");
      end_sim();
   end
endmodule : test_input_terminal_function_mux
